// *** rtl/etir_top.sv ***
/*
 * Event timer block: main counter, general configuration, status,
 * eight channels, line routing and processor message delivery.
 * Assumes a synchronous 32-bit register port (byte addresses, one-cycle
 * write and read strobes) and a message sink with a ready handshake.
 */
`default_nettype none
// Function
// - with legacy routing off, each timer uses its route field; capability lists choices.
// - timers 0 and 1 route only to IRQ20-23 on the APIC.
// - timer 2 routes to IRQ11 (both controllers) or IRQ20-23 on the APIC.
// - timer 3 routes to IRQ12 (both controllers) or IRQ20-23 on the APIC.
// - timers 4 to 7 deliver only as processor write messages.
// - a message writes the timer's message value to its message address.
// - message enable overrides and excludes line routing, even in legacy mode.
// - one-shot fires on counter equal comparator, again after wrap.
// - hardware never changes a one-shot comparator.
// - direct-load bit lets the next comparator half write load directly.
// - timer 0 is 32- or 64-bit, default 32; others 32-bit only.
// - periodic match adds the last written value to the comparator.
// - reading a periodic comparator gives the next match time.
// - a new value written while periodic is the next increment.
// - only timer 0 is periodic; a capability bit says so.
// - enable bit 0 at 10h halts counter and silences interrupts.
// - lines toward the 8259 are active high.
// - legacy routing sends timer 0 to IRQ0/IRQ2, timer 1 to IRQ8.
// - the 64-bit counter increments by one each clock while enabled.
module etir_top #(
	parameter logic [7:0] REV_ID = 8'h01, // Arbitrary value
	parameter logic [31:0] TICK_FS = 32'h004C_4B40
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire etir_pkg::etir_req_t req_in,
	output logic [31:0] rdata_out,
	output logic rvalid_out,
	output logic [etir_pkg::PIC_LINES-1:0] pic_irq_out,
	output logic [etir_pkg::APIC_LINES-1:0] apic_irq_out,
	output etir_pkg::etir_msg_t msg_out,
	input wire logic msg_ready_in
);
	import etir_pkg::*;

	typedef struct packed {
		logic en;
		logic leg;
		logic [63:0] cnt;
		logic [NTMR-1:0] sts;
		logic [NTMR-1:0] pend;
		logic [NTMR-1:0] edg;
		logic [PIC_LINES-1:0] pic;
		logic [APIC_LINES-1:0] apic;
		logic mv;
		logic [31:0] madr;
		logic [31:0] mdat;
		logic rv;
		logic [31:0] rd;
		logic [NTMR-1:0][31:0] mval;
		logic [NTMR-1:0][31:0] mtgt;
	} etir_top_t;

	etir_top_t q, d;
	etir_chan_t st [NTMR];
	etir_chan_t c;
	logic [NTMR-1:0] mt, ln, lvl_v, msg_v, ien_v, sel, sts_clr;
	logic tsel, found;
	logic [2:0] idx;
	logic [4:0] sub;

	// Timer page decode
	assign tsel = (req_in.addr[11:8] == OFS_TMR_PAGE);
	assign idx = req_in.addr[7:5];
	assign sub = req_in.addr[4:0];
	assign c = st[idx];

	// One channel per timer; only timer 0 is wide and periodic
	for (genvar i = 0; i < NTMR; i++) begin : g_chan
		assign sel[i] = req_in.wr && tsel && (idx == 3'(i));
		assign lvl_v[i] = st[i].lvl;
		assign msg_v[i] = st[i].msg_en;
		assign ien_v[i] = st[i].ien;
		// message enable keeps the timer off the lines
		assign ln[i] = q.en && st[i].ien && !st[i].msg_en
			&& (st[i].lvl ? q.sts[i] : q.edg[i]);
		etir_chan #(
			.PER_CAP(i == 0),
			.WIDE_CAP(i == 0),
			.RT_MASK(RT_MASKS[i])
		) u_chan (
			.clk_in(clk_in),
			.resetn_in(resetn_in),
			.count_in(q.cnt),
			.run_in(q.en),
			.sel_in(sel[i]),
			.req_in(req_in),
			.match_out(mt[i]),
			.st_out(st[i])
		);
	end

	// Status bits cleared by writing ones
	assign sts_clr = (req_in.wr && req_in.addr == OFS_STS) ? req_in.wdata[NTMR-1:0] : '0;

	// Next-state logic for the whole block
	always_comb begin
		d = q;
		found = 1'b0;

		if (q.en) begin
			d.cnt = q.cnt + 64'h1;
		end

		// Register writes outside the channels
		if (req_in.wr) begin
			unique case (req_in.addr)
				// overall enable at bit 0 of 10h
				OFS_GEN: begin
					d.en = req_in.wdata[GEN_EN_BIT];
					d.leg = req_in.wdata[GEN_LEG_BIT];
				end
				OFS_CNT_LO: d.cnt[31:0] = req_in.wdata;
				OFS_CNT_HI: d.cnt[63:32] = req_in.wdata;
				default: begin
				end
			endcase
			if (tsel && sub == OFS_T_MVAL) begin
				d.mval[idx] = req_in.wdata;
			end
			if (tsel && sub == OFS_T_MADR) begin
				d.mtgt[idx] = req_in.wdata;
			end
		end

		// level status is sticky; a new match beats the clear
		d.sts = (q.sts & ~sts_clr) | (mt & lvl_v);
		// Edge timers get one pulse per match
		d.edg = mt & ~lvl_v;

		// lines are active high, rebuilt every cycle
		d.pic = '0;
		d.apic = '0;
		for (int i = 0; i < NTMR; i++) begin
			if (ln[i]) begin
				if (q.leg && i == 0) begin
					// timer 0 replaces the legacy tick
					d.pic[LEG_T0_PIC] = 1'b1;
					d.apic[LEG_T0_APIC] = 1'b1;
				end else if (q.leg && i == 1) begin
					// timer 1 replaces the clock alarm
					d.pic[LEG_T1_IRQ] = 1'b1;
					d.apic[LEG_T1_IRQ] = 1'b1;
				end else if (RT_MASKS[i][st[i].rt]) begin
					if (st[i].rt < 5'(APIC_LINES)) begin
						d.apic[st[i].rt] = 1'b1;
					end
					if (st[i].rt < 5'(PIC_LINES)) begin
						d.pic[st[i].rt[3:0]] = 1'b1;
					end
				end
			end
		end

		// timers 4 to 7 only ever take this path
		d.pend = q.pend | (mt & msg_v & ien_v);
		// one write at a time, lowest timer first
		if (!q.mv || msg_ready_in) begin
			d.mv = 1'b0;
			for (int i = 0; i < NTMR; i++) begin
				if (!found && q.pend[i] && q.en) begin
					found = 1'b1;
					d.mv = 1'b1;
					d.madr = q.mtgt[i];
					d.mdat = q.mval[i];
					d.pend[i] = mt[i] && msg_v[i] && ien_v[i];
				end
			end
		end
		if (!q.en) begin
			d.pend = '0;
		end

		// Read path, answered one cycle later
		d.rv = req_in.rd;
		d.rd = '0;
		if (req_in.rd) begin
			if (tsel) begin
				unique case (sub)
					OFS_T_CFG: begin
						d.rd[CFG_LVL_BIT] = c.lvl;
						d.rd[CFG_IEN_BIT] = c.ien;
						d.rd[CFG_PER_BIT] = c.per;
						d.rd[CFG_PCAP_BIT] = (idx == 3'h0);
						d.rd[CFG_WCAP_BIT] = (idx == 3'h0);
						d.rd[CFG_DLD_BIT] = c.dld;
						d.rd[CFG_M32_BIT] = c.m32;
						d.rd[CFG_RT_LSB +: 5] = c.rt;
						d.rd[CFG_MSG_EN_BIT] = c.msg_en;
						d.rd[CFG_MSG_CAP_BIT] = 1'b1;
					end
					OFS_T_RCAP: d.rd = RT_MASKS[idx];
					OFS_T_CMP_LO: d.rd = c.cmp[31:0];
					OFS_T_CMP_HI: d.rd = c.cmp[63:32];
					OFS_T_MVAL: d.rd = q.mval[idx];
					OFS_T_MADR: d.rd = q.mtgt[idx];
					default: d.rd = '0;
				endcase
			end else begin
				unique case (req_in.addr)
					OFS_CAP: begin
						d.rd[7:0] = REV_ID;
						d.rd[CAP_NUM_LSB +: 5] = 5'(NTMR - 1);
						d.rd[CAP_CNT64_BIT] = 1'b1;
						d.rd[CAP_LEG_BIT] = 1'b1;
					end
					OFS_CAP_HI: d.rd = TICK_FS;
					OFS_GEN: begin
						d.rd[GEN_EN_BIT] = q.en;
						d.rd[GEN_LEG_BIT] = q.leg;
					end
					OFS_STS: d.rd[NTMR-1:0] = q.sts;
					OFS_CNT_LO: d.rd = q.cnt[31:0];
					OFS_CNT_HI: d.rd = q.cnt[63:32];
					default: d.rd = '0;
				endcase
			end
		end
	end

	// State register; everything returns to zero
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops
	assign rdata_out = q.rd;
	assign rvalid_out = q.rv;
	assign pic_irq_out = q.pic;
	assign apic_irq_out = q.apic;
	assign msg_out = '{valid: q.mv, addr: q.madr, data: q.mdat};

	property p_cnt_inc;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.en && !(req_in.wr && (req_in.addr == OFS_CNT_LO || req_in.addr == OFS_CNT_HI)))
		|=> (q.cnt == $past(q.cnt) + 64'h1);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc)
		else $error("main counter did not step by one");

	property p_halt;
		@(posedge clk_in) disable iff (!resetn_in)
		(!q.en && !req_in.wr) |=> $stable(q.cnt);
	endproperty
	a_halt: assert property (p_halt)
		else $error("main counter moved while disabled");

	property p_quiet;
		@(posedge clk_in) disable iff (!resetn_in)
		!q.en |=> (pic_irq_out == '0 && apic_irq_out == '0);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("interrupt line raised while disabled");

	property p_apic_targets;
		@(posedge clk_in) disable iff (!resetn_in)
		(apic_irq_out & 24'h0F_E6FB) == '0;
	endproperty
	a_apic_targets: assert property (p_apic_targets)
		else $error("APIC line outside the legal set");

	property p_pic_targets;
		@(posedge clk_in) disable iff (!resetn_in)
		(pic_irq_out & 16'hE6FE) == '0;
	endproperty
	a_pic_targets: assert property (p_pic_targets)
		else $error("8259 line outside the legal set");

	property p_leg_t0;
		@(posedge clk_in) disable iff (!resetn_in)
		q.leg |=> (pic_irq_out[LEG_T0_PIC] == $past(ln[0])
			&& apic_irq_out[LEG_T0_APIC] == $past(ln[0]));
	endproperty
	a_leg_t0: assert property (p_leg_t0)
		else $error("legacy timer 0 lines not driven");

	property p_leg_t1;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.leg && ln[1]) |=> (pic_irq_out[LEG_T1_IRQ] && apic_irq_out[LEG_T1_IRQ]);
	endproperty
	a_leg_t1: assert property (p_leg_t1)
		else $error("legacy timer 1 lines not driven");

	property p_msg_pend;
		@(posedge clk_in) disable iff (!resetn_in)
		(mt[5] && msg_v[5] && ien_v[5]) |=> q.pend[5];
	endproperty
	a_msg_pend: assert property (p_msg_pend)
		else $error("message timer match not held pending");

	property p_msg_excl;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.leg && st[0].msg_en) |=> !apic_irq_out[LEG_T0_APIC];
	endproperty
	a_msg_excl: assert property (p_msg_excl)
		else $error("line driven for a message timer");

	property p_msg_data;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.en && q.pend[0] && !q.mv) |=> (msg_out.valid && msg_out.data == $past(q.mval[0])
			&& msg_out.addr == $past(q.mtgt[0]));
	endproperty
	a_msg_data: assert property (p_msg_data)
		else $error("message did not carry timer 0 address and value");

	property p_msg_hold;
		@(posedge clk_in) disable iff (!resetn_in)
		(msg_out.valid && !msg_ready_in) |=> (msg_out.valid && $stable(msg_out.data));
	endproperty
	a_msg_hold: assert property (p_msg_hold)
		else $error("message dropped before it was taken");

	property p_lvl_hold;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.sts[2] && !sts_clr[2]) |=> q.sts[2];
	endproperty
	a_lvl_hold: assert property (p_lvl_hold)
		else $error("level status lost without a clear");
endmodule
`default_nettype wire

// *** rtl/etir_pkg.sv ***
/*
 * Shared constants and types for the event timer with interrupt routing:
 * register offsets, field positions, reset values and routing masks.
 * Assumes a 32-bit register port with byte addresses and one clock.
 */
`default_nettype none
package etir_pkg;
	localparam int NTMR = 8;
	localparam int PIC_LINES = 16;
	localparam int APIC_LINES = 24;

	// Register byte offsets
	localparam logic [11:0] OFS_CAP = 12'h000;
	localparam logic [11:0] OFS_CAP_HI = 12'h004;
	localparam logic [11:0] OFS_GEN = 12'h010;
	localparam logic [11:0] OFS_STS = 12'h020;
	localparam logic [11:0] OFS_CNT_LO = 12'h0F0;
	localparam logic [11:0] OFS_CNT_HI = 12'h0F4;
	localparam logic [3:0] OFS_TMR_PAGE = 4'h1;
	localparam logic [4:0] OFS_T_CFG = 5'h00;
	localparam logic [4:0] OFS_T_RCAP = 5'h04;
	localparam logic [4:0] OFS_T_CMP_LO = 5'h08;
	localparam logic [4:0] OFS_T_CMP_HI = 5'h0C;
	localparam logic [4:0] OFS_T_MVAL = 5'h10;
	localparam logic [4:0] OFS_T_MADR = 5'h14;

	// General configuration fields
	localparam int GEN_EN_BIT = 0;
	localparam int GEN_LEG_BIT = 1;
	// Capability fields
	localparam int CAP_NUM_LSB = 8;
	localparam int CAP_CNT64_BIT = 13;
	localparam int CAP_LEG_BIT = 15;
	// Timer configuration fields
	localparam int CFG_LVL_BIT = 1;
	localparam int CFG_IEN_BIT = 2;
	localparam int CFG_PER_BIT = 3;
	localparam int CFG_PCAP_BIT = 4;
	localparam int CFG_WCAP_BIT = 5;
	localparam int CFG_DLD_BIT = 6;
	localparam int CFG_M32_BIT = 8;
	localparam int CFG_RT_LSB = 9;
	localparam int CFG_MSG_EN_BIT = 14;
	localparam int CFG_MSG_CAP_BIT = 15;

	// Legacy replacement lines
	localparam int LEG_T0_PIC = 0;
	localparam int LEG_T0_APIC = 2;
	localparam int LEG_T1_IRQ = 8;

	// Legal route targets, one bit per IRQ number
	localparam logic [31:0] RT_MASK_T01 = 32'h00F0_0000;
	localparam logic [31:0] RT_MASK_T2 = 32'h00F0_0800;
	localparam logic [31:0] RT_MASK_T3 = 32'h00F0_1000;
	localparam logic [31:0] RT_MASK_NONE = 32'h0000_0000;
	localparam logic [NTMR-1:0][31:0] RT_MASKS = {RT_MASK_NONE, RT_MASK_NONE,
		RT_MASK_NONE, RT_MASK_NONE, RT_MASK_T3, RT_MASK_T2, RT_MASK_T01, RT_MASK_T01};

	// Reset values
	localparam logic [63:0] CMP_RST = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic M32_RST = 1'b1;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} etir_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
	} etir_msg_t;

	typedef struct packed {
		logic lvl;
		logic ien;
		logic per;
		logic dld;
		logic m32;
		logic [4:0] rt;
		logic msg_en;
		logic [63:0] cmp;
		logic [63:0] period;
	} etir_chan_t;
endpackage
`default_nettype wire

// *** rtl/etir_chan.sv ***
/*
 * One timer channel: configuration, comparator, period and match.
 * Assumes the parent decodes the timer page and presents sel_in for
 * a write that targets this channel; the main counter is shared.
 */
`default_nettype none
module etir_chan #(
	parameter bit PER_CAP = 1'b0,
	parameter bit WIDE_CAP = 1'b0,
	parameter logic [31:0] RT_MASK = etir_pkg::RT_MASK_NONE
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [63:0] count_in,
	input wire logic run_in,
	input wire logic sel_in,
	input wire etir_pkg::etir_req_t req_in,
	output logic match_out,
	output etir_pkg::etir_chan_t st_out
);
	import etir_pkg::*;

	etir_chan_t q, d;
	logic [63:0] sum;
	logic wr_cfg, wr_lo, wr_hi;
	logic [4:0] rt_new;

	// Write strobes for this channel
	assign wr_cfg = sel_in && (req_in.addr[4:0] == OFS_T_CFG);
	assign wr_lo = sel_in && (req_in.addr[4:0] == OFS_T_CMP_LO);
	assign wr_hi = sel_in && (req_in.addr[4:0] == OFS_T_CMP_HI);
	assign rt_new = req_in.wdata[CFG_RT_LSB +: 5];

	assign sum = q.m32 ? {q.cmp[63:32], q.cmp[31:0] + q.period[31:0]} : q.cmp + q.period;
	assign match_out = run_in && (q.m32 ? (count_in[31:0] == q.cmp[31:0])
		: (count_in == q.cmp));
	assign st_out = q;

	// Next state; a direct-load write beats the periodic reload in the same cycle
	always_comb begin
		d = q;
		if (match_out && q.per) begin
			d.cmp = sum;
		end
		if (wr_cfg) begin
			d.lvl = req_in.wdata[CFG_LVL_BIT];
			d.ien = req_in.wdata[CFG_IEN_BIT];
			d.per = req_in.wdata[CFG_PER_BIT] & PER_CAP;
			d.dld = req_in.wdata[CFG_DLD_BIT];
			d.m32 = WIDE_CAP ? req_in.wdata[CFG_M32_BIT] : 1'b1;
			d.msg_en = req_in.wdata[CFG_MSG_EN_BIT];
			if (RT_MASK[rt_new]) begin
				d.rt = rt_new;
			end
		end
		// direct load per half, then self-clear
		if (wr_lo) begin
			d.period[31:0] = req_in.wdata;
			if (!q.per || q.dld) begin
				d.cmp[31:0] = req_in.wdata;
			end
			d.dld = 1'b0;
		end
		// new period applies at next match
		if (wr_hi) begin
			d.period[63:32] = req_in.wdata;
			if (!q.per || q.dld) begin
				d.cmp[63:32] = req_in.wdata;
			end
			d.dld = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			q <= '0;
			q.cmp <= CMP_RST;
			q.m32 <= M32_RST;
		end else begin
			q <= d;
		end
	end

	property p_oneshot_fixed;
		@(posedge clk_in) disable iff (!resetn_in)
		(!q.per && !sel_in) |=> (q.cmp == $past(q.cmp));
	endproperty
	a_oneshot_fixed: assert property (p_oneshot_fixed)
		else $error("one-shot comparator changed without a write");

	property p_per_add;
		@(posedge clk_in) disable iff (!resetn_in)
		(match_out && q.per && !sel_in) |=> (q.m32
			? (q.cmp[31:0] == $past(q.cmp[31:0]) + $past(q.period[31:0])
				&& q.cmp[63:32] == $past(q.cmp[63:32]))
			: (q.cmp == $past(q.cmp) + $past(q.period)));
	endproperty
	a_per_add: assert property (p_per_add)
		else $error("periodic comparator did not advance by the period");

	property p_narrow;
		@(posedge clk_in) disable iff (!resetn_in)
		!WIDE_CAP |-> q.m32;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("narrow timer left 32-bit mode");
endmodule
`default_nettype wire

// *** verification/etir_sink.sv ***
/*
 * Processor message sink standing in for the message interface.
 * Assumes the bench drives stall_in just after each rising clock edge.
 */
`default_nettype none
module etir_sink (
	input wire logic clk_in,
	input wire etir_pkg::etir_msg_t msg_in,
	input wire logic stall_in,
	output logic ready_out,
	output etir_pkg::etir_msg_t got_out
);
	import etir_pkg::*;
	// Ready follows the bench, so stalls come at random
	assign ready_out = !stall_in;
	always_ff @(posedge clk_in) begin
		got_out <= (msg_in.valid && ready_out) ? msg_in : '0;
	end
endmodule
`default_nettype wire

// *** verification/tb_event_timer_irq_routing.sv ***
/*
 * Self-checking bench for the event timer: register map, routing,
 * one-shot, periodic, legacy lines and message delivery.
 * Assumes the design package and the message sink are compiled first.
 */
`default_nettype none
module tb_event_timer_irq_routing;
	timeunit 1ns;
	timeprecision 100ps;
	import etir_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value
	localparam int MIN_PER = 32'h0000_03E8; // 5 us at a 5 ns clock
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	etir_req_t req = '0;
	logic stall = 1'b0;
	logic ready, rvalid, lines;
	logic [31:0] rdata, v, c, p, q;
	logic [31:0] rs = 32'h0000_F852;
	logic [15:0] pic;
	logic [23:0] apic;
	etir_msg_t msg, got;
	etir_msg_t exp_q[$];
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int wcyc, t0, at;

	// Clock and a cycle count for latency checks
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) cyc <= cyc + 1;

	etir_top #(.REV_ID(REV)) etir_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.req_in(req), .rdata_out(rdata), .rvalid_out(rvalid), .pic_irq_out(pic),
		.apic_irq_out(apic), .msg_out(msg), .msg_ready_in(ready));
	etir_sink etir_sink_inst (.clk_in(clk_in), .msg_in(msg), .stall_in(stall),
		.ready_out(ready), .got_out(got));

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	function automatic logic [11:0] ta(input int n, input logic [4:0] o);
		return {4'h1, 3'(n), o};
	endfunction

	// Timer config word; the 32-bit mode bit always stays set
	function automatic logic [31:0] cfg(input logic lvl, ien, per, dld,
		input logic [4:0] rt, input logic msg_en);
		return {16'h0, 1'b0, msg_en, rt, 1'b1, 1'b0, dld, 2'b0, per, ien, lvl, 1'b0};
	endfunction

	task automatic chk(input string n, input logic [64:0] s, input logic [64:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic close_out();
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Register port: one-cycle strobes, answer one cycle after a read
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		#1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		#1 wcyc = cyc;
		req = '0;
	endtask

	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_in);
		#1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_in);
		#1 req = '0;
		chk("rvalid", rvalid, 1'b1);
		chk(n, rdata, e);
	endtask

	// Edge index at which a line is first seen high, or -1
	task automatic wt(input logic sel, input int i, output int at_o);
		at_o = -1;
		for (int k = 0; k < 1200 && at_o < 0; k++) begin
			@(posedge clk_in);
			#1 if ((sel ? apic[i] : pic[i]) === 1'b1) at_o = cyc;
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		// Capabilities, reset values and refused writes
		rchk("cap", OFS_CAP, {16'h0, 8'hA7, REV});
		rchk("gen", OFS_GEN, 32'h0);
		rchk("unmapped", 12'h0F8, 32'h0);
		for (int n = 0; n < NTMR; n++) begin
			c = (n < 4) ? 32'h00F0_0000 : 32'h0;
			c[11] = (n == 2);
			c[12] = (n == 3);
			rchk("route_cap", ta(n, OFS_T_RCAP), c);
			rchk("cfg_rst", ta(n, OFS_T_CFG), n == 0 ? 32'h8130 : 32'h8100);
		end
		wr(ta(1, OFS_T_CFG), 32'h0000_0008);
		rchk("t1_fixed", ta(1, OFS_T_CFG), 32'h8100);
		wr(ta(0, OFS_T_CFG), cfg(0, 0, 0, 0, 5'h0B, 0));
		rchk("t0_bad_route", ta(0, OFS_T_CFG), 32'h8130);
		// One-shot, level, IRQ11 on both controllers
		c = 32'h14 + (rnd() & 32'hF);
		wr(ta(2, OFS_T_CFG), cfg(1, 1, 0, 0, 5'h0B, 0));
		rchk("t2_route", ta(2, OFS_T_CFG), 32'h9706);
		wr(ta(2, OFS_T_CMP_LO), c);
		wr(OFS_GEN, 32'h1);
		t0 = wcyc;
		wt(1'b0, 11, at);
		chk("oneshot_at", at - t0, c + 2);
		chk("apic11", apic[11], 1'b1);
		repeat (6) @(posedge clk_in);
		#1 chk("level_hold", pic[11], 1'b1);
		rchk("sts", OFS_STS, 32'h0000_0004);
		rchk("oneshot_cmp", ta(2, OFS_T_CMP_LO), c);
		wr(OFS_STS, 32'h4);
		repeat (2) @(posedge clk_in);
		#1 chk("level_clr", pic[11], 1'b0);
		wr(OFS_GEN, 32'h0);
		rchk("halted", OFS_CNT_LO, 32'(wcyc - t0));
		// Second match after the low word wraps, edge mode
		wr(ta(2, OFS_T_CFG), cfg(0, 1, 0, 0, 5'h0B, 0));
		wr(OFS_CNT_LO, 32'hFFFF_FFFE);
		wr(OFS_GEN, 32'h1);
		t0 = wcyc;
		wt(1'b1, 11, at);
		chk("wrap_at", at - t0, c + 4);
		@(posedge clk_in);
		#1 chk("edge_pulse", apic[11], 1'b0);
		// Periodic restart on timer 0, IRQ20
		wr(OFS_GEN, 32'h0);
		wr(ta(2, OFS_T_CFG), cfg(0, 0, 0, 0, 5'h0B, 0));
		wr(OFS_CNT_LO, 32'h0);
		wr(OFS_CNT_HI, 32'h0);
		// periods no shorter than 5 us
		p = MIN_PER + (rnd() & 32'hF);
		q = MIN_PER + (rnd() & 32'h7);
		wr(ta(0, OFS_T_CFG), cfg(0, 1, 1, 1, 5'h14, 0));
		wr(ta(0, OFS_T_CMP_LO), p);
		wr(ta(0, OFS_T_CFG), cfg(0, 1, 1, 1, 5'h14, 0));
		wr(ta(0, OFS_T_CMP_HI), 32'h0);
		wr(OFS_GEN, 32'h1);
		t0 = wcyc;
		wt(1'b1, 20, at);
		chk("per_first", at - t0, p + 2);
		chk("no_pic", pic, 16'h0);
		rchk("next_match", ta(0, OFS_T_CMP_LO), 2 * p);
		wr(ta(0, OFS_T_CMP_LO), q);
		t0 = at;
		wt(1'b1, 20, at);
		chk("per_second", at - t0, p);
		t0 = at;
		wt(1'b1, 20, at);
		chk("per_new", at - t0, q);
		wr(OFS_GEN, 32'h0);
		wt(1'b1, 20, at);
		chk("suppressed", at, -1);
		// Legacy routing, messages on timers 0 and 5, level line on timer 1
		wr(OFS_GEN, 32'h2);
		wr(OFS_CNT_LO, 32'h0);
		c = 32'h18 + (rnd() & 32'hF);
		for (int n = 0; n < 6; n += 5) begin
			wr(ta(n, OFS_T_CFG), cfg(0, 1, 0, 0, 5'h14, 1));
			wr(ta(n, OFS_T_CMP_LO), c);
			v = rnd();
			wr(ta(n, OFS_T_MVAL), v);
			p = rnd();
			wr(ta(n, OFS_T_MADR), p);
			exp_q.push_back('{valid: 1'b1, addr: p, data: v});
		end
		wr(ta(1, OFS_T_CFG), cfg(1, 1, 0, 0, 5'h14, 0));
		wr(ta(1, OFS_T_CMP_LO), c + 8);
		wr(OFS_GEN, 32'h3);
		lines = 1'b0;
		for (int k = 0; k < 300; k++) begin
			@(posedge clk_in);
			#1 v = rnd();
			stall = v[0];
			lines |= pic[0] | apic[2] | apic[20];
			if (got.valid === 1'b1) begin
				chk("message", got, exp_q.size() > 0 ? exp_q.pop_front() : '0);
			end
		end
		stall = 1'b0;
		chk("msg_left", exp_q.size(), 0);
		chk("msg_no_line", lines, 1'b0);
		chk("legacy_pic8", pic[8], 1'b1);
		chk("legacy_apic8", apic[8], 1'b1);
		// 64-bit compare on timer 0: low half meets, high half never does
		wr(OFS_GEN, 32'h0);
		wr(ta(0, OFS_T_CFG), cfg(0, 1, 0, 0, 5'h15, 0) & ~32'h0000_0100);
		wr(ta(0, OFS_T_CMP_LO), c);
		wr(ta(0, OFS_T_CMP_HI), 32'h1);
		wr(OFS_CNT_LO, 32'h0);
		rchk("t0_wide", ta(0, OFS_T_CFG), 32'h0000_AA34);
		wr(OFS_GEN, 32'h1);
		wt(1'b1, 21, at);
		chk("wide_cmp", at, -1);
		close_out();
	end

	// Watchdog far beyond the few thousand cycles the run needs
	initial begin
		#(20000 * 5);
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
